/* logic/seeprm_pkg.sv */
// package for the two-wire serial eeprom target engine
// assumes a 40 MHz ref_clk that oversamples the bus clock and data pins
package seeprm_pkg;
  localparam int          ADDR_W          = 10;
  localparam int          PAGE_W          = 4;
  localparam int          MEM_BYTES       = 1024;
  localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
  localparam logic [3:0]  TYPE_ID         = 4'h5;  // arbitrary identity value
  localparam int          SEL_BIT         = 3;
  localparam int          HI_ADDR_MSB     = 2;
  localparam int          HI_ADDR_LSB     = 1;
  localparam int          DIR_BIT         = 0;
  localparam int          CLK_PERIOD_NS   = 25;
  localparam int          PROG_TIME_NS    = 5000000;
  localparam int          PROG_CYCLES     = PROG_TIME_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic scl;
    logic sda;
    logic protect;
  } seeprm_pins_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } seeprm_evt_t;
endpackage

/* logic/seeprm_bus_sense.sv */
// synchroniser and edge finder for the bus clock and data pins
// assumes pins are asynchronous to ref_clk; start, stop, rise and fall are ref_clk pulses, sda and protect are levels
`timescale 1ns/1ps
module seeprm_bus_sense
  import seeprm_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire seeprm_pkg::seeprm_pins_t pins,
  output seeprm_pkg::seeprm_evt_t       evt,
  output logic                          protect
);
  logic [2:0] meta;
  logic [2:0] sync;
  logic       scl_d;
  logic       sda_d;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= 3'h7;
      sync <= 3'h7;
    end
    else
    begin
      meta <= {pins.scl, pins.sda, pins.protect};
      sync <= meta;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= sync[2];
      sda_d <= sync[1];
    end
  end

  // start/stop are data edges while the clock stays high
  always_comb
  begin
    evt.start = scl_d && sync[2] && sda_d && !sync[1];
    evt.stop  = scl_d && sync[2] && !sda_d && sync[1];
    evt.rise  = !scl_d && sync[2];
    evt.fall  = scl_d && !sync[2];
    evt.sda   = sync[1];
  end

  assign protect = sync[0];
endmodule // seeprm_bus_sense

/* logic/seeprm_engine.sv */
// two-wire serial eeprom target: page write, ack polling, protection, reads
// assumes an open-drain data pin with external pull-up and a bus master
`timescale 1ns/1ps
module seeprm_engine
  import seeprm_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
)
(
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  input  wire logic                     protect_in,
  input  wire logic                     select_strap,
  output logic                          sda_out,
  output logic                          sda_oe,
  output logic                          programming
);
  import seeprm_pkg::*;

  if (PROG_CYC < 1)
  begin : g_bad_prog_cyc
    $error("programming cycle count must be at least one");
  end

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_DEV   = 7'b0000010,
    ST_WORD  = 7'b0000100,
    ST_DATA  = 7'b0001000,
    ST_READ  = 7'b0010000,
    ST_RACK  = 7'b0100000,
    ST_ACK   = 7'b1000000
  } seeprm_state_t;

  seeprm_pins_t          pins;
  seeprm_evt_t           evt;
  logic                  protect;
  seeprm_state_t         state;
  seeprm_state_t         after_ack;
  logic [3:0]            bit_cnt;
  logic [7:0]            shift;
  logic [ADDR_W-1:0]     addr;
  logic [7:0]            mem [MEM_BYTES];
  logic [7:0]            page_buf [1<<PAGE_W];
  logic [(1<<PAGE_W)-1:0] page_used;
  logic [ADDR_W-PAGE_W-1:0] page_row;
  logic                  write_pending;
  logic                  do_ack;
  logic [31:0]           prog_cnt;
  logic                  sel_meta;
  logic                  sel_bit;

  function automatic logic dev_match(input logic [7:0] b, input logic sel);
    dev_match = (b[7:4] == TYPE_ID) && (b[SEL_BIT] == sel);
  endfunction

  function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
    page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 4'h1};
  endfunction

  assign pins = '{scl: scl_in, sda: sda_in, protect: protect_in};

  seeprm_bus_sense u_sense (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pins    (pins),
    .evt     (evt),
    .protect (protect)
  );

  // strap sampled on every clock, during reset too, never under the asynchronous reset
  always_ff @(posedge ref_clk)
  begin
    sel_meta <= select_strap;
    sel_bit  <= sel_meta;
  end

  // protocol state machine
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state     <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      do_ack    <= 1'b0;
    end
    else if (evt.start)
    begin
      state   <= ST_DEV;
      bit_cnt <= 4'h0;
    end
    else if (evt.stop)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE:
          state <= ST_IDLE;
        ST_DEV, ST_WORD, ST_DATA:
        begin
          if (evt.rise)
          begin
            shift   <= {shift[6:0], evt.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (evt.fall && bit_cnt == 4'h8)
          begin
            bit_cnt <= 4'h0;
            state   <= ST_ACK;
            do_ack  <= 1'b0;
            if (state == ST_DEV)
            begin
              if (dev_match(shift, sel_bit) && !programming)
              begin
                do_ack    <= 1'b1;
                after_ack <= shift[DIR_BIT] ? ST_READ : ST_WORD;
              end
              else
                after_ack <= ST_IDLE;
            end
            else
            begin
              do_ack    <= 1'b1;
              after_ack <= ST_DATA;
            end
          end
        end
        ST_ACK:
          if (evt.fall)
            state <= do_ack ? after_ack : ST_IDLE;
        ST_READ:
          if (evt.fall)
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h7)
              state <= ST_RACK;
          end
        // wait for the fall after the master's ack so bit 7 is launched there
        ST_RACK:
          if (evt.rise && evt.sda)
            state <= ST_IDLE;
          else if (evt.fall)
          begin
            bit_cnt <= 4'h0;
            state   <= ST_READ;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // address counter, page collection; counter persists across operations
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      addr          <= '0;
      page_used     <= '0;
      page_row      <= '0;
      write_pending <= 1'b0;
    end
    else if (evt.fall && bit_cnt == 4'h8 && (state == ST_DEV || state == ST_WORD
                                              || state == ST_DATA))
    begin
      if (state == ST_DEV && dev_match(shift, sel_bit) && !programming)
      begin
        page_used     <= '0;
        write_pending <= 1'b0;
        if (!shift[DIR_BIT])
          addr[ADDR_W-1:8] <= shift[HI_ADDR_MSB:HI_ADDR_LSB];
      end
      else if (state == ST_WORD)
      begin
        addr[7:0] <= shift;
        page_row  <= {addr[ADDR_W-1:8], shift[7:PAGE_W]};
      end
      else if (state == ST_DATA)
      begin
        page_used[addr[PAGE_W-1:0]] <= 1'b1;
        write_pending <= 1'b1;
        addr <= page_inc(addr);
      end
    end
    else if (state == ST_RACK && evt.rise && !evt.sda)
      addr <= addr + 10'h001;
    else if (state == ST_READ && evt.fall && bit_cnt == 4'h7)
      addr <= addr; // counter steps at the master's ack or nack bit, not here
    else if (evt.stop)
      write_pending <= 1'b0;
    if (state == ST_RACK && evt.rise && evt.sda)
      addr <= addr + 10'h001;
  end

  always_ff @(posedge ref_clk)
  begin
    if (state == ST_DATA && evt.fall && bit_cnt == 4'h8)
      page_buf[addr[PAGE_W-1:0]] <= shift;
  end

  // programming timer; protect sampled at the stop only
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      programming <= 1'b0;
      prog_cnt    <= 32'h0;
    end
    else if (programming)
    begin
      if (prog_cnt == 32'(PROG_CYC - 1))
        programming <= 1'b0;
      prog_cnt <= prog_cnt + 32'h1;
    end
    else if (evt.stop && write_pending && !protect)
    begin
      programming <= 1'b1;
      prog_cnt    <= 32'h0;
    end
  end

  // array: loaded erased, written in one go at the stop
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < MEM_BYTES; i++)
        mem[i] <= ERASED_BYTE;
    end
    else if (evt.stop && write_pending && !protect && !programming)
    begin
      for (int j = 0; j < (1<<PAGE_W); j++)
        if (page_used[j])
          mem[{page_row, 4'(j)}] <= page_buf[j];
    end
  end

  // data pin driver: ack low, or read bits msb first
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end
    else if (evt.start || evt.stop)
      sda_oe <= 1'b0;
    else if (evt.fall)
    begin
      sda_out <= 1'b0;
      if ((state == ST_DEV || state == ST_WORD || state == ST_DATA) && bit_cnt == 4'h8)
        sda_oe <= (state == ST_DEV) ? (dev_match(shift, sel_bit) && !programming)
                                    : 1'b1;
      else if ((state == ST_ACK && do_ack && after_ack == ST_READ)
               || state == ST_RACK
               || (state == ST_READ && bit_cnt != 4'h7))
      begin
        // open drain: drive only the zeros
        sda_oe <= !mem[addr][3'(7 - ((state == ST_READ) ? bit_cnt + 4'h1 : 4'h0))];
      end
      else
        sda_oe <= 1'b0;
    end
    else if (state == ST_RACK && evt.rise && !evt.sda)
      sda_oe <= 1'b0;
  end

  // next read byte starts on the fall after the master's ack
  // (handled by the ST_RACK term of the driver, as that fall returns the machine to ST_READ)
endmodule // seeprm_engine

/* verification/seeprm_engine_sva.sv */
// checker for the eeprom target engine, port level only
// assumes the bench holds protect steady for several clocks around a stop
`timescale 1ns/1ps
module seeprm_engine_chk #(
  parameter int PROG_CYC = 50
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic protect_in,
  input wire logic select_strap,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic programming
);
  int unsigned cnt;

  // length of the current programming run
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      cnt <= 0;
    else if (programming)
      cnt <= cnt + 1;
    else
      cnt <= 0;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_open_drain: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");
  a_busy_no_ack: assert property (programming |-> !sda_oe)
    else $error("acknowledge while programming");
  a_prog_length: assert property ($fell(programming) |-> cnt == PROG_CYC)
    else $error("programming run has wrong length");
  a_prog_holds: assert property (programming && cnt < PROG_CYC - 1 |=> programming)
    else $error("programming cut short");
  a_prog_at_stop: assert property ($rose(programming) |-> scl_in && sda_in)
    else $error("programming began outside a stop");
  a_prot_blocks: assert property ($rose(programming) |-> !$past(protect_in, 6))
    else $error("programming began while protected");
  a_prog_spacing: assert property ($fell(programming) |=> !programming [*8])
    else $error("programming restarted at once");
  a_idle_release: assert property (scl_in [*8] |-> !sda_oe)
    else $error("data held low on idle bus");
endmodule // seeprm_engine_chk

bind seeprm_engine seeprm_engine_chk #(.PROG_CYC(PROG_CYC)) chk_inst (
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .protect_in(protect_in), .select_strap(select_strap), .sda_out(sda_out),
  .sda_oe(sda_oe), .programming(programming));

/* verification/seeprm_master.sv */
// bus master model: drives the bus clock, pulls the data wire low
// assumes a pulled-up data wire; one bit takes 8 ref_clk, 200 ns
`timescale 1ns/1ps
module seeprm_master (
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic q();
    repeat (2) @(posedge ref_clk);
  endtask

  // also serves as repeated start after a ninth bit
  task automatic start();
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask

  // clock left high afterwards: it stands still between frames
  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask

  task automatic xbit(input logic b, output logic r);
    sda_low <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask

  // lst is the ninth bit sent: 1 releases for an ack, 0 acks a read byte
  task automatic xfer(input logic [7:0] tx, input logic lst, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      xbit(tx[i], rx[i]);
    xbit(lst, ack);
  endtask
endmodule // seeprm_master

/* verification/test_seeprm_engine.sv */
// self-checking bench: random page writes, polling, protection, reads
// assumes the master model and a pulled-up data wire
`timescale 1ns/1ps
module test_seeprm_engine;
  import seeprm_pkg::*;
  localparam int PCYC = 200;
  logic       ref_clk, rst, protect_in, select_strap, sda_out, sda_oe, programming;
  logic       scl, m_low, ack;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] rx;
  logic [9:0] cur, a;
  int         mismatches, checks, n;
  wire logic  sda = !(m_low || (sda_oe && !sda_out));

  seeprm_engine #(.PROG_CYC(PCYC)) seeprm_engine_inst (.ref_clk(ref_clk), .rst(rst),
    .scl_in(scl), .sda_in(sda), .protect_in(protect_in), .select_strap(select_strap),
    .sda_out(sda_out), .sda_oe(sda_oe), .programming(programming));
  seeprm_master seeprm_master_inst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(m_low));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] dev(logic [1:0] hi, logic rw);
    return {TYPE_ID, select_strap, hi, rw};
  endfunction

  task automatic xf(logic [7:0] tx, logic lst);
    seeprm_master_inst.xfer(tx, lst, rx, ack);
  endtask

  task automatic wr(logic [9:0] wa, int cnt, logic prot, logic flip);
    logic [7:0] d;
    int         i;
    protect_in <= prot;
    seeprm_master_inst.start();
    xf(dev(wa[9:8], 1'b0), 1'b1);
    chk("dev ack", 0, ack);
    xf(wa[7:0], 1'b1);
    chk("word ack", 0, ack);
    for (i = 0; i < cnt; i++)
    begin
      d = 8'($urandom);
      xf(d, 1'b1);
      chk("data ack", 0, ack);
      if (!prot)
        mem[{wa[9:4], wa[3:0] + i[3:0]}] = d;
    end
    seeprm_master_inst.stop();
    repeat (8) @(posedge ref_clk);
    chk("programming", !prot, programming);
    if (flip)
      protect_in <= 1'b1;
    i = 0;
    do
    begin
      seeprm_master_inst.start();
      xf(dev(2'b00, 1'b0), 1'b1);
      seeprm_master_inst.stop();
      i++;
    end while (ack && i < 60);
    chk("poll ack", 0, ack);
    chk("poll busy", !prot, i > 1);
    protect_in <= 1'b0;
  endtask

  task automatic rd(logic [9:0] ra, int cnt, logic rnd);
    if (rnd)
    begin
      seeprm_master_inst.start();
      xf(dev(ra[9:8], 1'b0), 1'b1);
      xf(ra[7:0], 1'b1);
      chk("dummy ack", 0, ack);
      cur = ra;
    end
    seeprm_master_inst.start();
    xf(dev(2'($urandom), 1'b1), 1'b1);
    chk("read ack", 0, ack);
    for (int i = 0; i < cnt; i++)
    begin
      xf(8'hFF, i == cnt - 1);
      chk("read data", mem[cur], rx);
      cur++;
    end
    seeprm_master_inst.stop();
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    rst = 1'b1;
    protect_in = 1'b0;
    mismatches = 0;
    checks = 0;
    cur = 0;
    foreach (mem[k]) mem[k] = ERASED_BYTE;
    void'($urandom(22742));
    select_strap = 1'($urandom);
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(10'h000, 2, 1'b0);
    $display("test erased read done");
    for (int t = 0; t < 6; t++)
    begin
      a = 10'($urandom);
      n = (t == 0) ? 1 : (t == 1) ? 16 : (t == 2) ? 16 : 1 + $urandom % 16;
      wr(a, n, t == 4, t == 3);
      rd({a[9:4], 4'h0}, 16, 1'b1);
      $display("test write %0d bytes done", n);
    end
    rd(10'h3FE, 4, 1'b1);
    rd(cur, 3, 1'b0);
    $display("test read wrap done");
    seeprm_master_inst.start();
    xf(dev(2'b00, 1'b0) ^ 8'h08, 1'b1);
    chk("select nack", 1, ack);
    seeprm_master_inst.start();
    xf(dev(2'b00, 1'b0) ^ 8'hF0, 1'b1);
    seeprm_master_inst.stop();
    chk("type nack", 1, ack);
    $display("test address mismatch done");
    report_and_stop();
  end
endmodule // test_seeprm_engine
